/* File: logic/ir_serial_port_config.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ir_serial_port_config
    import ispc_pkg::*;
#(
    parameter int STEP_LEN = STEP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [7:0] regRdData,
    // Serial port side
    input wire logic uartTxd,
    input wire logic irTxPulse,
    input wire logic txBusy,
    output logic rxToPort,
    // Configuration and status outputs
    output logic midiEnable,
    output logic highSpeedEnable,
    output logic [2:0] irMode,
    output logic halfDuplex,
    output logic rxBlanked,
    // Pins
    input wire logic second_port_receive_pin,
    input wire logic alternate_optical_receive_pin,
    output logic second_port_transmit_pin,
    output logic alternate_optical_transmit_pin
);
    // ==========================================
    // Register file
    logic [7:0] modeReg_r, modeReg_nxt;
    logic [7:0] optReg_r, optReg_nxt;
    logic [7:0] tmoReg_r, tmoReg_nxt;
    logic [7:0] rdData_r, rdData_nxt;

    always_comb begin
        modeReg_nxt = modeReg_r;
        optReg_nxt = optReg_r;
        tmoReg_nxt = tmoReg_r;
        rdData_nxt = READ_ZERO;
        if (regWrStrobe) begin
            case (regAddr)
                ADDR_MODE: modeReg_nxt = regWrData & MODE_WMASK;
                ADDR_OPT: optReg_nxt = regWrData & OPT_WMASK;
                ADDR_TMO: tmoReg_nxt = regWrData;
                default: begin
                end
            endcase
        end
        if (regRdStrobe) begin
            case (regAddr)
                ADDR_MODE: rdData_nxt = modeReg_r;
                ADDR_OPT: rdData_nxt = optReg_r;
                ADDR_TMO: rdData_nxt = tmoReg_r;
                default: rdData_nxt = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            modeReg_r <= MODE_RESET;
            optReg_r <= OPT_RESET;
            tmoReg_r <= TMO_RESET;
            rdData_r <= READ_ZERO;
        end else begin
            modeReg_r <= modeReg_nxt;
            optReg_r <= optReg_nxt;
            tmoReg_r <= tmoReg_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign midiEnable = modeReg_r[MODE_MIDI_BIT];
    assign highSpeedEnable = modeReg_r[MODE_HS_BIT];
    assign irMode = optReg_r[OPT_MODE_MSB:OPT_MODE_LSB];
    assign halfDuplex = optReg_r[OPT_DUPLEX_BIT];

    // ==========================================
    // Receive pin synchronisers
    logic [1:0] rxPins;
    logic [1:0] rxSync1_r, rxSync2_r, rxSync3_r, rxStable_r;
    logic [1:0] rxStable_nxt;

    assign rxPins = {alternate_optical_receive_pin, second_port_receive_pin};

    always_comb begin
        rxStable_nxt = rxStable_r;
        for (int i = 0; i < 2; i++) begin
            if (rxSync2_r[i] == rxSync3_r[i]) begin
                rxStable_nxt[i] = rxSync3_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rxSync1_r <= {2{UART_IDLE}};
            rxSync2_r <= {2{UART_IDLE}};
            rxSync3_r <= {2{UART_IDLE}};
            rxStable_r <= {2{UART_IDLE}};
        end else begin
            rxSync1_r <= rxPins;
            rxSync2_r <= rxSync1_r;
            rxSync3_r <= rxSync2_r;
            rxStable_r <= rxStable_nxt;
        end
    end

    // ==========================================
    // Half-duplex blanking timer
    ispc_blank_if blk ();

    assign blk.start = optReg_r[OPT_DUPLEX_BIT] & txBusy;
    assign blk.steps = tmoReg_r;

    ispc_blank_timer #(
        .STEP_LEN(CYC_W'(STEP_LEN))
    ) u_timer (
        .ref_clk(ref_clk),
        .reset(reset),
        .blk(blk.timer)
    );

    // ==========================================
    // Pin routing and polarity
    logic irOn;
    logic muxAlt;
    logic txLow;
    logic rxLow;
    logic blankNow;
    logic rxSel;
    logic txLevel;
    logic sp2Tx_r, sp2Tx_nxt;
    logic altTx_r, altTx_nxt;
    logic rxOut_r, rxOut_nxt;
    logic blank_r, blank_nxt;

    assign irOn = (irMode == IRM_IRDA) || (irMode == IRM_ASK);
    assign muxAlt = optReg_r[OPT_MUX_BIT];
    assign txLow = optReg_r[OPT_TXPOL_BIT];
    assign rxLow = optReg_r[OPT_RXPOL_BIT];
    assign blankNow = optReg_r[OPT_DUPLEX_BIT] & (txBusy | blk.busy);
    assign rxSel = muxAlt ? rxStable_r[PIN_ALT] : rxStable_r[PIN_SECOND];
    assign txLevel = irTxPulse ^ txLow;

    always_comb begin
        sp2Tx_nxt = uartTxd;
        altTx_nxt = txLow;
        rxOut_nxt = rxStable_r[PIN_SECOND];
        blank_nxt = 1'h0;
        if (irOn) begin
            blank_nxt = blankNow;
            if (muxAlt) begin
                sp2Tx_nxt = UART_IDLE;
                altTx_nxt = txLevel;
            end else begin
                sp2Tx_nxt = txLevel;
                altTx_nxt = txLow;
            end
            if (blankNow) begin
                rxOut_nxt = RX_NO_PULSE;
            end else begin
                rxOut_nxt = rxSel ^ rxLow;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sp2Tx_r <= UART_IDLE;
            altTx_r <= OPT_RESET[OPT_TXPOL_BIT];
            rxOut_r <= UART_IDLE;
            blank_r <= 1'h0;
        end else begin
            sp2Tx_r <= sp2Tx_nxt;
            altTx_r <= altTx_nxt;
            rxOut_r <= rxOut_nxt;
            blank_r <= blank_nxt;
        end
    end

    assign second_port_transmit_pin = sp2Tx_r;
    assign alternate_optical_transmit_pin = altTx_r;
    assign rxToPort = rxOut_r;
    assign rxBlanked = blank_r;

    // ==========================================
    // Checks
    sequence s_mode_write;
        regWrStrobe && regAddr == ADDR_MODE;
    endsequence

    sequence s_ir_rx_open;
        irOn && !blankNow;
    endsequence

    sequence s_opt_write;
        regWrStrobe && regAddr == ADDR_OPT;
    endsequence

    sequence s_tmo_write;
        regWrStrobe && regAddr == ADDR_TMO;
    endsequence

    sequence s_zero_release;
        $fell(txBusy) && $past(halfDuplex) && $past(tmoReg_r) == 8'h00;
    endsequence

    a_midi_enable: assert property (@(posedge ref_clk) disable iff (reset)
        s_mode_write |=> midiEnable == $past(regWrData[MODE_MIDI_BIT]))
        else $error("MIDI enable not taken from write");

    a_high_speed: assert property (@(posedge ref_clk) disable iff (reset)
        s_mode_write |=> highSpeedEnable == $past(regWrData[MODE_HS_BIT]) && modeReg_r[7:2] == 6'h00)
        else $error("High speed enable wrong");

    a_reset_defaults: assert property (@(posedge ref_clk)
        reset |=> modeReg_r == MODE_RESET && optReg_r == OPT_RESET && tmoReg_r == TMO_RESET)
        else $error("Reset defaults not restored");

    a_rx_polarity: assert property (@(posedge ref_clk) disable iff (reset)
        s_ir_rx_open |=> rxToPort == ($past(rxSel) ^ $past(rxLow)))
        else $error("Receive polarity wrong");

    a_tx_polarity: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && !muxAlt |=> second_port_transmit_pin == ($past(irTxPulse) ^ $past(txLow)))
        else $error("Transmit polarity wrong");

    a_full_duplex_open: assert property (@(posedge ref_clk) disable iff (reset)
        !halfDuplex && !$past(halfDuplex) |-> !blk.busy ##1 !rxBlanked)
        else $error("Blanking in full duplex");

    a_alt_pins: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && muxAlt |=> second_port_transmit_pin == UART_IDLE
            && alternate_optical_transmit_pin == ($past(irTxPulse) ^ $past(txLow)))
        else $error("Alternate pin routing wrong");

    a_blank_during_tx: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && halfDuplex && txBusy |=> rxBlanked && rxToPort == RX_NO_PULSE)
        else $error("Reception not blanked while transmitting");

    a_read_answer: assert property (@(posedge ref_clk) disable iff (reset)
        regRdStrobe && regAddr == ADDR_TMO && !regWrStrobe |=> regRdData == $past(tmoReg_r)
            ##1 (regRdData == READ_ZERO || $past(regRdStrobe)))
        else $error("Timeout readback wrong");

    // ==========================================
    // Field, routing and hold checks
    a_protocol_field: assert property (@(posedge ref_clk) disable iff (reset)
        s_opt_write |=> irMode == $past(regWrData[OPT_MODE_MSB:OPT_MODE_LSB]))
        else $error("Protocol field not taken from write");

    a_duplex_field: assert property (@(posedge ref_clk) disable iff (reset)
        s_opt_write |=> halfDuplex == $past(regWrData[OPT_DUPLEX_BIT]))
        else $error("Duplex select not taken from write");

    a_timeout_store: assert property (@(posedge ref_clk) disable iff (reset)
        s_tmo_write |=> tmoReg_r == $past(regWrData))
        else $error("Timeout not taken from write");

    a_plain_tx_path: assert property (@(posedge ref_clk) disable iff (reset)
        !irOn |=> second_port_transmit_pin == $past(uartTxd) && alternate_optical_transmit_pin == $past(txLow))
        else $error("Serial transmit not passed through");

    a_plain_rx_path: assert property (@(posedge ref_clk) disable iff (reset)
        !irOn |=> !rxBlanked && rxToPort == $past(rxStable_r[PIN_SECOND]))
        else $error("Serial receive not passed through");

    a_alt_tx_idle: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && !muxAlt |=> alternate_optical_transmit_pin == $past(txLow))
        else $error("Unused alternate transmit pin not idle");

    a_alt_rx_select: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && muxAlt && !blankNow |=> rxToPort == ($past(rxStable_r[PIN_ALT]) ^ $past(rxLow)))
        else $error("Alternate receive pin not selected");

    a_timer_blank: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && halfDuplex && blk.busy |=> rxBlanked)
        else $error("Reception open during timeout");

    a_full_rx_open: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && !halfDuplex |=> !rxBlanked && rxToPort == ($past(rxSel) ^ $past(rxLow)))
        else $error("Full duplex reception blanked");

    a_mode_readback: assert property (@(posedge ref_clk) disable iff (reset)
        regRdStrobe && regAddr == ADDR_MODE |=> regRdData == $past(modeReg_r))
        else $error("Mode readback wrong");

    a_opt_readback: assert property (@(posedge ref_clk) disable iff (reset)
        regRdStrobe && regAddr == ADDR_OPT |=> regRdData == $past(optReg_r))
        else $error("Option readback wrong");

    a_pin_reset: assert property (@(posedge ref_clk)
        reset |=> second_port_transmit_pin == UART_IDLE && rxToPort == UART_IDLE && !rxBlanked
            && alternate_optical_transmit_pin == OPT_RESET[OPT_TXPOL_BIT] && regRdData == READ_ZERO)
        else $error("Pins not at reset levels");

    a_zero_release: assert property (@(posedge ref_clk) disable iff (reset)
        s_zero_release ##1 !txBusy |=> !rxBlanked)
        else $error("Zero timeout held blanking");

    a_midi_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !(regWrStrobe && regAddr == ADDR_MODE) |=> $stable(midiEnable))
        else $error("MIDI enable changed without write");

    a_speed_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !(regWrStrobe && regAddr == ADDR_MODE) |=> $stable(highSpeedEnable))
        else $error("High speed changed without write");

    a_opt_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !(regWrStrobe && regAddr == ADDR_OPT) |=> $stable(optReg_r))
        else $error("Options changed without write");

    a_tmo_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !(regWrStrobe && regAddr == ADDR_TMO) |=> $stable(tmoReg_r))
        else $error("Timeout changed without write");

    a_ask_route: assert property (@(posedge ref_clk) disable iff (reset)
        irMode == IRM_ASK && !muxAlt |=> second_port_transmit_pin == $past(txLevel))
        else $error("Shift keyed pulse not routed");

    a_standard_tx: assert property (@(posedge ref_clk) disable iff (reset)
        irMode == IRM_STANDARD |=> second_port_transmit_pin == $past(uartTxd))
        else $error("Standard mode transmit wrong");

    a_dark_level: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && !muxAlt && !irTxPulse |=> second_port_transmit_pin == $past(txLow))
        else $error("Transmit dark level wrong");

    a_blank_rx_zero: assert property (@(posedge ref_clk) disable iff (reset)
        irOn && blankNow |=> rxBlanked && rxToPort == RX_NO_PULSE)
        else $error("Blanked reception passed pulses");

    a_sync_agree: assert property (@(posedge ref_clk) disable iff (reset)
        rxSync2_r[PIN_SECOND] != rxSync3_r[PIN_SECOND] |=> $stable(rxStable_r[PIN_SECOND]))
        else $error("Receive level taken before flops agreed");
endmodule : ir_serial_port_config
`default_nettype wire

/* File: logic/ispc_pkg.sv */
package ispc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] ADDR_MODE = 8'hf0;
    localparam logic [7:0] ADDR_OPT = 8'hf1;
    localparam logic [7:0] ADDR_TMO = 8'hf2;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET = 8'h02;
    localparam logic [7:0] TMO_RESET = 8'h03;
    localparam logic [7:0] MODE_WMASK = 8'h03;
    localparam logic [7:0] OPT_WMASK = 8'h7f;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ==========================================
    // Field positions
    localparam int MODE_MIDI_BIT = 0;
    localparam int MODE_HS_BIT = 1;
    localparam int OPT_RXPOL_BIT = 0;
    localparam int OPT_TXPOL_BIT = 1;
    localparam int OPT_DUPLEX_BIT = 2;
    localparam int OPT_MODE_LSB = 3;
    localparam int OPT_MODE_MSB = 5;
    localparam int OPT_MUX_BIT = 6;
    // ==========================================
    // Protocol codes
    localparam logic [2:0] IRM_STANDARD = 3'h0;
    localparam logic [2:0] IRM_IRDA = 3'h1;
    localparam logic [2:0] IRM_ASK = 3'h2;
    // ==========================================
    // Line levels and pin indices
    localparam logic UART_IDLE = 1'h1;
    localparam logic RX_NO_PULSE = 1'h0;
    localparam int PIN_SECOND = 0;
    localparam int PIN_ALT = 1;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_NS = 100000;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_W = 14;
    // ==========================================
    // Blanking timer states
    typedef enum logic [1:0] {
        ISPC_IDLE,
        ISPC_HOLD,
        ISPC_EXTEND
    } ispc_blank_state_t;
endpackage : ispc_pkg

/* File: logic/ispc_blank_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ispc_blank_if;
    logic start;
    logic [7:0] steps;
    logic busy;
    modport ctrl (output start, output steps, input busy);
    modport timer (input start, input steps, output busy);
endinterface : ispc_blank_if
`default_nettype wire

/* File: logic/ispc_blank_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module ispc_blank_timer
    import ispc_pkg::*;
#(
    parameter logic [CYC_W-1:0] STEP_LEN = CYC_W'(STEP_CYCLES)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control side
    ispc_blank_if.timer blk
);
    // ==========================================
    // Step counter
    ispc_blank_state_t state_r, state_nxt;
    logic [7:0] stepsLeft_r, stepsLeft_nxt;
    logic [CYC_W-1:0] cyc_r, cyc_nxt;
    logic busy_r, busy_nxt;

    always_comb begin
        state_nxt = state_r;
        stepsLeft_nxt = stepsLeft_r;
        cyc_nxt = cyc_r;
        busy_nxt = busy_r;
        case (state_r)
            ISPC_IDLE, ISPC_HOLD: begin
                if (blk.start) begin
                    state_nxt = ISPC_HOLD;
                    busy_nxt = 1'h1;
                    stepsLeft_nxt = blk.steps;
                    cyc_nxt = STEP_LEN - CYC_W'(1);
                end else if (state_r == ISPC_HOLD && stepsLeft_r != 8'h00) begin
                    state_nxt = ISPC_EXTEND;
                end else begin
                    state_nxt = ISPC_IDLE;
                    busy_nxt = 1'h0;
                end
            end
            ISPC_EXTEND: begin
                if (blk.start) begin
                    state_nxt = ISPC_HOLD;
                    stepsLeft_nxt = blk.steps;
                    cyc_nxt = STEP_LEN - CYC_W'(1);
                end else if (cyc_r != CYC_W'(0)) begin
                    cyc_nxt = cyc_r - CYC_W'(1);
                end else if (stepsLeft_r > 8'h01) begin
                    stepsLeft_nxt = stepsLeft_r - 8'h01;
                    cyc_nxt = STEP_LEN - CYC_W'(1);
                end else begin
                    stepsLeft_nxt = 8'h00;
                    state_nxt = ISPC_IDLE;
                    busy_nxt = 1'h0;
                end
            end
            default: begin
                state_nxt = ISPC_IDLE;
                busy_nxt = 1'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ISPC_IDLE;
            stepsLeft_r <= 8'h00;
            cyc_r <= '0;
            busy_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            stepsLeft_r <= stepsLeft_nxt;
            cyc_r <= cyc_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign blk.busy = busy_r;

    // ==========================================
    // Checks
    sequence s_tx_end_zero;
        state_r == ISPC_HOLD && !blk.start && stepsLeft_r == 8'h00;
    endsequence

    sequence s_step_wrap;
        state_r == ISPC_EXTEND && !blk.start && cyc_r == CYC_W'(0) && stepsLeft_r > 8'h01;
    endsequence

    a_zero_no_extend: assert property (@(posedge ref_clk) disable iff (reset)
        s_tx_end_zero |=> !busy_r && state_r == ISPC_IDLE)
        else $error("Zero timeout extended blanking");

    a_step_decrement: assert property (@(posedge ref_clk) disable iff (reset)
        s_step_wrap |=> stepsLeft_r == $past(stepsLeft_r) - 8'h01 && cyc_r == STEP_LEN - CYC_W'(1) && busy_r)
        else $error("Step count did not advance by one");
endmodule : ispc_blank_timer
`default_nettype wire

/* File: tb/ispc_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module ispc_partner (
    // Clock
    input wire logic ref_clk,
    // Stimulus from the bench
    input wire logic lightIn,
    input wire logic rxActiveLow,
    input wire logic txActiveLow,
    input wire logic useAlt,
    // Device pins
    input wire logic spTx,
    input wire logic altTx,
    output logic spRx,
    output logic altRx,
    // Observed transmit light
    output logic lightSeen
);
    // ==========================================
    // Transceiver lines
    logic toggle_r = 1'b0;
    always_ff @(posedge ref_clk) begin
        toggle_r <= ~toggle_r;
    end
    // Unselected receive pin carries a changing pattern
    assign spRx = useAlt ? toggle_r : (lightIn ^ rxActiveLow);
    assign altRx = useAlt ? (lightIn ^ rxActiveLow) : toggle_r;
    assign lightSeen = (useAlt ? altTx : spTx) ^ txActiveLow;
endmodule : ispc_partner
`default_nettype wire

/* File: tb/ir_serial_port_config_test.sv */
`timescale 1ns/1ns
`default_nettype none
module ir_serial_port_config_test;
    import ispc_pkg::*;
    localparam int STEP = 4;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [7:0] regRdData;
    logic uartTxd = 1'b1;
    logic irTxPulse = 1'b0;
    logic txBusy = 1'b0;
    logic rxToPort, midiEnable, highSpeedEnable, halfDuplex, rxBlanked;
    logic [2:0] irMode;
    logic spRx, altRx, spTx, altTx, lightSeen;
    logic lightIn = 1'b0;
    logic rxLow = 1'b0;
    logic txLow = 1'b1;
    logic useAlt = 1'b0;
    logic [7:0] modeE = 8'h00;
    logic [7:0] optE = 8'h02;
    logic [7:0] got;
    int fail_count = 0;
    int n_compared = 0;
    logic [23:0] rows [0:11] = '{24'hf00303, 24'hf00101, 24'hf00202, 24'hf00000, 24'hf17f7f, 24'hf10808,
        24'hf11010, 24'hf11818, 24'hf12020, 24'hf2ffff, 24'hf20000, 24'hf35500};
    logic [7:0] opts [0:4] = '{8'h00, 8'h0a, 8'h48, 8'h53, 8'h09};

    always #5 ref_clk = ~ref_clk;

    ir_serial_port_config #(.STEP_LEN(STEP)) dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .uartTxd(uartTxd), .irTxPulse(irTxPulse), .txBusy(txBusy), .rxToPort(rxToPort),
        .midiEnable(midiEnable), .highSpeedEnable(highSpeedEnable), .irMode(irMode), .halfDuplex(halfDuplex),
        .rxBlanked(rxBlanked), .second_port_receive_pin(spRx), .alternate_optical_receive_pin(altRx),
        .second_port_transmit_pin(spTx), .alternate_optical_transmit_pin(altTx));

    ispc_partner partner (.ref_clk(ref_clk), .lightIn(lightIn), .rxActiveLow(rxLow), .txActiveLow(txLow),
        .useAlt(useAlt), .spTx(spTx), .altTx(altTx), .spRx(spRx), .altRx(altRx), .lightSeen(lightSeen));

    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge ref_clk);
        regWrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge ref_clk);
        regRdStrobe <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    task automatic cfg(input logic [7:0] o);
        wr(ADDR_OPT, o);
        rxLow <= o[0];
        txLow <= o[1];
        useAlt <= o[6];
    endtask : cfg

    task automatic blank(input logic [7:0] o, input logic [7:0] n, input logic on);
        wr(ADDR_TMO, n);
        cfg(o);
        lightIn <= 1'b1;
        @(posedge ref_clk);
        txBusy <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("blanked", {7'h0, rxBlanked}, {7'h0, on});
        chk("rx while blanked", {7'h0, rxToPort}, {7'h0, !on});
        @(posedge ref_clk);
        txBusy <= 1'b0;
        if (n != 0) begin
            repeat (n * STEP) @(posedge ref_clk);
            #1;
            chk("extended blank", {7'h0, rxBlanked}, {7'h0, on});
        end
        repeat (8) @(posedge ref_clk);
        #1;
        chk("unblanked", {7'h0, rxBlanked}, 8'h00);
        chk("rx after blank", {7'h0, rxToPort}, 8'h01);
    endtask : blank

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #500000;
        fail_count++;
        stop_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_MODE, got);
        chk("mode reset", got, MODE_RESET);
        rd(ADDR_OPT, got);
        chk("option reset", got, 8'h02);
        rd(ADDR_TMO, got);
        chk("timeout reset", got, 8'h03);
        chk("alt tx idle", {7'h0, altTx}, 8'h01);
        for (int i = 0; i < 12; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], got);
            chk("readback", got, rows[i][7:0]);
            if (rows[i][23:16] == ADDR_MODE) modeE = rows[i][7:0];
            if (rows[i][23:16] == ADDR_OPT) optE = rows[i][7:0];
            chk("midi", {7'h0, midiEnable}, {7'h0, modeE[0]});
            chk("high speed", {7'h0, highSpeedEnable}, {7'h0, modeE[1]});
            chk("protocol", {5'h0, irMode}, {5'h0, optE[5:3]});
            chk("duplex", {7'h0, halfDuplex}, {7'h0, optE[2]});
        end
        for (int i = 0; i < 5; i++) begin
            cfg(opts[i]);
            for (int p = 0; p < 2; p++) begin
                @(posedge ref_clk);
                irTxPulse <= p[0];
                uartTxd <= p[0];
                lightIn <= p[0];
                repeat (8) @(posedge ref_clk);
                #1;
                chk("tx light", {7'h0, lightSeen}, {7'h0, p[0]});
                chk("rx pulse", {7'h0, rxToPort}, {7'h0, p[0]});
                chk("idle tx pin", {7'h0, opts[i][6] ? spTx : altTx}, {7'h0, opts[i][6] | opts[i][1]});
            end
        end
        blank(8'h0c, 8'h02, 1'b1);
        blank(8'h0c, 8'h00, 1'b1);
        blank(8'h08, 8'h02, 1'b0);
        wr(ADDR_MODE, 8'h03);
        wr(ADDR_TMO, 8'h77);
        wr(ADDR_OPT, 8'h4c);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_MODE, got);
        chk("mode after reset", got, 8'h00);
        rd(ADDR_TMO, got);
        chk("timeout after reset", got, 8'h03);
        rd(ADDR_OPT, got);
        chk("option after reset", got, OPT_RESET);
        chk("protocol after reset", {5'h0, irMode}, 8'h00);
        chk("midi after reset", {7'h0, midiEnable}, 8'h00);
        chk("duplex after reset", {7'h0, halfDuplex}, 8'h00);
        stop_test();
    end
endmodule : ir_serial_port_config_test
`default_nettype wire
